// ---- verilog/dwt_pkg.sv ----
`default_nettype none
package dwt_pkg;
  // Clock rate and the 1/8 microsecond base tick of the interval timer.
  localparam int         CLK_MHZ         = 20;
  localparam int         TICKS_PER_US    = 8;
  localparam logic [4:0] TICK_ACC_STEP   = 5'(TICKS_PER_US);
  localparam logic [4:0] TICK_ACC_WRAP   = 5'(CLK_MHZ);
  // Byte offsets of the register map; the bus carries A6..A1 as a word index.
  localparam logic [6:0] OFS_CTRL        = 7'h00;
  localparam logic [6:0] OFS_PRESCALE    = 7'h02;
  localparam logic [6:0] OFS_INTERVAL    = 7'h04;
  localparam logic [6:0] OFS_WDATA       = 7'h06;
  localparam logic [6:0] OFS_WPTR        = 7'h08;
  localparam logic [6:0] OFS_START       = 7'h0E;
  localparam logic [6:0] OFS_DAC0        = 7'h10;
  localparam logic [6:0] OFS_VECTOR      = 7'h21;
  // Control register fields.
  localparam int         CTL_CH_LSB      = 0;
  localparam int         CTL_AUTOINC_BIT = 4;
  localparam int         CTL_TRIG_LSB    = 5;
  localparam int         CTL_MODE_LSB    = 8;
  localparam int         START_BIT       = 0;
  localparam logic [1:0] TRIG_ALL        = 2'h0;
  localparam logic [1:0] TRIG_EXT_ONLY   = 2'h1;
  localparam logic [1:0] TRIG_DRIVE_OUT  = 2'h2;
  localparam logic [2:0] MODE_SINGLE_REG = 3'h1;
  localparam logic [2:0] MODE_SINGLE_MEM = 3'h2;
  localparam logic [2:0] MODE_ONCE       = 3'h3;
  localparam logic [2:0] MODE_ONCE_IRQ   = 3'h4;
  localparam logic [2:0] MODE_CONT       = 3'h5;
  // Geometry and reset values.
  localparam int         NUM_CH          = 8;
  localparam int         MEM_DEPTH       = 2048;
  localparam logic [10:0] LAST_ADDR      = 11'h7FF;
  localparam int         FIFO_DEPTH      = 4;
  localparam logic [2:0] TRIG_OUT_CYCLES = 3'h4;
  localparam logic [15:0] RESET_WORD     = 16'h0000;
  localparam logic [7:0]  RESET_VECTOR   = 8'h00;
endpackage
`default_nettype wire

// ---- verilog/dwt_top.sv ----
// Overview of operation
// - Control trigger code 01: only low pulses on the outside trigger pin start conversions.
// - Each outside trigger pulse updates all output channels together.
// - In outside-trigger-only mode the interval timer does nothing.
// - In outside-trigger-only mode the trigger pin is an input, never driven.
// - A continuous-cycle master drives its trigger pin; its start bit starts all modules.
// - Control 0100H enables all trigger sources and single conversion from channel registers.
// - Start write 0001H at 0EH moves all channel registers to converters at once.
// - Output codes pass unchanged as two's complement bipolar values.
// - Low control bits pick the waveform bank reached by host data accesses.
// - Data written at 06H lands at the address held at 08H, in selected bank.
// - With auto-increment set, the waveform address advances after each data write.
// - Interval in microseconds is prescaler times timer divided by eight.
// - Cycle-once mode converts at each interval until one full pass, then stops.
// - Control 0400H selects cycle-once with an interrupt at the end of the pass.
// - The interrupt request line is withdrawn during the acknowledge cycle.
// - On an interrupt select cycle the vector goes on D7..D0 with acknowledge.
// - Control bits 10..8 select the conversion mode.
// - The software start bit does nothing in outside-trigger-only mode.
// - A cycle-once pass converts addresses 0 through 2047 in order.
`timescale 1ns/1ps
`default_nettype none

module dwt_fifo #(
  parameter int WIDTH = 30,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             rst_b_i,
  // Filling side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Draining side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign out_data_o  = store[rd_ptr_reg];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clock_i)
  begin
    if (push)
    begin
      store[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // dwt_fifo

module dwt_top
  import dwt_pkg::*;
(
  // Clock and reset from the carrier
  input  wire logic          clock_i,
  input  wire logic          rst_b_i,
  // Carrier bus
  input  wire logic          io_sel_n_i,
  input  wire logic          int_sel_n_i,
  input  wire logic          rd_wr_n_i,
  input  wire logic [5:0]    addr_i,
  input  wire logic [15:0]   data_i,
  output logic      [15:0]   data_o,
  output logic               data_oe_o,
  output logic               ack_n_o,
  output logic               irq_req_n_o,
  // Outside trigger pin
  input  wire logic          outside_trigger_n_i,
  output logic               outside_trigger_n_o,
  output logic               outside_trigger_oe_o,
  // Converter side
  output logic      [127:0]  dac_code_o,
  output logic               dac_load_o
);
  typedef enum {BUS_IDLE, BUS_SERVE, BUS_MEMRD, BUS_ACK, BUS_HOLD} dwt_bus_t;
  typedef enum {SEQ_IDLE, SEQ_FETCH, SEQ_LOAD} dwt_seq_t;

  dwt_bus_t     bus_reg;
  dwt_seq_t     seq_reg;
  logic [15:0]  ctrl_reg, prescale_reg, interval_reg, wptr_reg;
  logic [7:0]   vector_reg;
  logic [15:0]  dac_reg [NUM_CH];
  logic [15:0]  stage_reg [NUM_CH];
  logic [15:0]  wave_mem [NUM_CH*MEM_DEPTH];
  logic [15:0]  mem_q_reg;
  logic [5:0]   req_addr_reg;
  logic         req_rd_reg, req_int_reg;
  logic [15:0]  req_data_reg;
  logic [2:0]   trig_sync_reg;
  logic         trig_level_reg, running_reg, sw_start_reg, fetch_vld_reg;
  logic [3:0]   fetch_ch_reg;
  logic [2:0]   fetch_ch_d_reg, trig_out_cnt_reg;
  logic [10:0]  conv_addr_reg;
  logic [4:0]   tick_acc_reg;
  logic [15:0]  pre_cnt_reg, int_cnt_reg;
  logic [2:0]   mode, bank;
  logic [1:0]   trig_mode;
  logic         ext_only, ext_fall, trig_ev, timer_ev, base_tick, pre_tick;
  logic         conv_go, cycle_mode, seq_idle, wdata_wr, fifo_in_ready;
  logic         fifo_out_valid, fifo_out_ready;
  logic [29:0]  fifo_out_data;
  logic [13:0]  rd_index;

  assign mode      = ctrl_reg[CTL_MODE_LSB +: 3];
  assign trig_mode = ctrl_reg[CTL_TRIG_LSB +: 2];
  assign bank      = ctrl_reg[CTL_CH_LSB +: 3];
  assign ext_only  = (trig_mode == TRIG_EXT_ONLY);
  assign seq_idle  = (seq_reg == SEQ_IDLE);
  assign cycle_mode = (mode == MODE_ONCE) || (mode == MODE_ONCE_IRQ) || (mode == MODE_CONT);

  // Outside trigger: three flops; a level counts once the last two agree.
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      trig_sync_reg  <= 3'h7;
      trig_level_reg <= 1'b1;
    end
    else
    begin
      trig_sync_reg <= {trig_sync_reg[1:0], outside_trigger_n_i};
      if (trig_sync_reg[1] == trig_sync_reg[2])
      begin
        trig_level_reg <= trig_sync_reg[2];
      end
    end
  end
  assign ext_fall = trig_level_reg && (trig_sync_reg[2:1] == 2'b00) && !outside_trigger_oe_o;

  // A driving master ignores its own pin; ext-only mode ignores the start bit.
  assign trig_ev  = ext_fall || (sw_start_reg && !ext_only);
  assign timer_ev = pre_tick && (int_cnt_reg <= 16'h0001) && running_reg && !ext_only;
  always_comb
  begin
    conv_go = 1'b0;
    if (cycle_mode && running_reg)
    begin
      conv_go = timer_ev || ext_fall;
    end
    else if (mode == MODE_SINGLE_REG || mode == MODE_SINGLE_MEM || cycle_mode)
    begin
      conv_go = trig_ev;
    end
  end

  // Interval timer: 1/8 us ticks by fractional accumulation, then two down counters.
  assign base_tick = (tick_acc_reg + TICK_ACC_STEP) >= TICK_ACC_WRAP;
  assign pre_tick  = base_tick && (pre_cnt_reg <= 16'h0001);
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      tick_acc_reg <= '0;
      pre_cnt_reg  <= RESET_WORD;
      int_cnt_reg  <= RESET_WORD;
    end
    else if (!running_reg)
    begin
      tick_acc_reg <= '0;
      pre_cnt_reg  <= prescale_reg;
      int_cnt_reg  <= interval_reg;
    end
    else
    begin
      tick_acc_reg <= base_tick ? tick_acc_reg + TICK_ACC_STEP - TICK_ACC_WRAP
                                : tick_acc_reg + TICK_ACC_STEP;
      if (base_tick)
      begin
        pre_cnt_reg <= pre_tick ? prescale_reg : pre_cnt_reg - 16'h0001;
      end
      if (pre_tick)
      begin
        int_cnt_reg <= (int_cnt_reg <= 16'h0001) ? interval_reg
                                                  : int_cnt_reg - 16'h0001;
      end
    end
  end

  // Conversion sequencer. A trigger that lands while a fetch is underway is dropped.
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      seq_reg        <= SEQ_IDLE;
      fetch_ch_reg   <= '0;
      fetch_ch_d_reg <= '0;
      fetch_vld_reg  <= 1'b0;
      running_reg    <= 1'b0;
      conv_addr_reg  <= '0;
    end
    else
    begin
      fetch_vld_reg  <= (seq_reg == SEQ_FETCH) && (fetch_ch_reg < 4'(NUM_CH));
      fetch_ch_d_reg <= fetch_ch_reg[2:0];
      if (!cycle_mode)
      begin
        running_reg <= 1'b0;
      end
      case (seq_reg)
        SEQ_IDLE:
        begin
          if (conv_go)
          begin
            fetch_ch_reg <= '0;
            if (cycle_mode && !running_reg)
            begin
              running_reg   <= 1'b1;
              conv_addr_reg <= '0;
            end
            seq_reg <= (mode == MODE_SINGLE_REG) ? SEQ_LOAD : SEQ_FETCH;
          end
        end
        SEQ_FETCH:
        begin
          if (fetch_ch_reg < 4'(NUM_CH))
          begin
            fetch_ch_reg <= fetch_ch_reg + 4'h1;
          end
          else if (!fetch_vld_reg)
          begin
            seq_reg <= SEQ_LOAD;
          end
        end
        SEQ_LOAD:
        begin
          seq_reg <= SEQ_IDLE;
          if (cycle_mode && running_reg)
          begin
            conv_addr_reg <= conv_addr_reg + 11'h001;
            if (conv_addr_reg == LAST_ADDR && mode != MODE_CONT)
            begin
              running_reg <= 1'b0;
            end
          end
        end
        default:
        begin
          seq_reg <= SEQ_IDLE;
        end
      endcase
    end
  end

  // Shared read port: the sequencer has priority, the bus reads only while it idles.
  // A single conversion from memory takes the host pointer, not the pass address.
  assign rd_index = (seq_reg != SEQ_FETCH)    ? {bank, wptr_reg[10:0]}
                  : (mode == MODE_SINGLE_MEM) ? {fetch_ch_reg[2:0], wptr_reg[10:0]}
                  : {fetch_ch_reg[2:0], conv_addr_reg};
  always_ff @(posedge clock_i)
  begin
    mem_q_reg <= wave_mem[rd_index];
    if (fetch_vld_reg)
    begin
      stage_reg[fetch_ch_d_reg] <= mem_q_reg;
    end
    if (fifo_out_valid && fifo_out_ready)
    begin
      wave_mem[fifo_out_data[29:16]] <= fifo_out_data[15:0];
    end
  end

  // Memory writes queue here; draining pauses while the sequencer fetches.
  assign wdata_wr       = (bus_reg == BUS_SERVE) && !req_rd_reg && !req_int_reg
                       && (req_addr_reg == OFS_WDATA[6:1]) && fifo_in_ready;
  assign fifo_out_ready = (seq_reg != SEQ_FETCH);
  dwt_fifo #(.WIDTH(30), .DEPTH(FIFO_DEPTH)) u_wfifo (
    .clock_i     (clock_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (wdata_wr),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   ({bank, wptr_reg[10:0], req_data_reg}),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out_data)
  );

  // Converter outputs: every channel updates on the same edge, codes unaltered.
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      dac_code_o <= '0;
      dac_load_o <= 1'b0;
    end
    else
    begin
      dac_load_o <= (seq_reg == SEQ_LOAD);
      if (seq_reg == SEQ_LOAD)
      begin
        for (int c = 0; c < NUM_CH; c++)
        begin
          dac_code_o[c*16 +: 16] <= (mode == MODE_SINGLE_REG) ? dac_reg[c]
                                                                : stage_reg[c];
        end
      end
    end
  end

  // Trigger pin: driven only as master, a short low pulse per conversion.
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      outside_trigger_oe_o <= 1'b0;
      outside_trigger_n_o  <= 1'b1;
      trig_out_cnt_reg     <= '0;
    end
    else
    begin
      outside_trigger_oe_o <= (trig_mode == TRIG_DRIVE_OUT);
      if (dac_load_o && trig_mode == TRIG_DRIVE_OUT)
      begin
        trig_out_cnt_reg <= TRIG_OUT_CYCLES;
      end
      else if (trig_out_cnt_reg != '0)
      begin
        trig_out_cnt_reg <= trig_out_cnt_reg - 3'h1;
      end
      outside_trigger_n_o <= !((dac_load_o && trig_mode == TRIG_DRIVE_OUT)
                               || trig_out_cnt_reg > 3'h1);
    end
  end

  // Interrupt request: set at the end of a pass, released by acknowledge.
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      irq_req_n_o <= 1'b1;
    end
    else if (seq_reg == SEQ_LOAD && running_reg && mode == MODE_ONCE_IRQ
             && conv_addr_reg == LAST_ADDR)
    begin
      irq_req_n_o <= 1'b0;
    end
    else if (bus_reg == BUS_SERVE && req_int_reg)
    begin
      irq_req_n_o <= 1'b1;
    end
  end

  // Carrier bus slave: one request is latched, served, acknowledged for one cycle.
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      bus_reg      <= BUS_IDLE;
      req_addr_reg <= '0;
      req_rd_reg   <= 1'b0;
      req_int_reg  <= 1'b0;
      req_data_reg <= RESET_WORD;
      ack_n_o      <= 1'b1;
      data_o       <= RESET_WORD;
      data_oe_o    <= 1'b0;
    end
    else
    begin
      ack_n_o   <= 1'b1;
      data_oe_o <= 1'b0;
      case (bus_reg)
        BUS_IDLE:
        begin
          // The carrier holds line 0 acknowledge with A1 low.
          if (!io_sel_n_i || (!int_sel_n_i && !addr_i[0]))
          begin
            req_addr_reg <= addr_i;
            req_rd_reg   <= rd_wr_n_i;
            req_int_reg  <= io_sel_n_i;
            req_data_reg <= data_i;
            bus_reg      <= BUS_SERVE;
          end
        end
        BUS_SERVE:
        begin
          if (req_int_reg)
          begin
            data_o  <= {8'h00, vector_reg};
            bus_reg <= BUS_ACK;
          end
          else if (!req_rd_reg)
          begin
            if (req_addr_reg != OFS_WDATA[6:1] || fifo_in_ready)
            begin
              bus_reg <= BUS_ACK;
            end
          end
          else if (req_addr_reg == OFS_WDATA[6:1])
          begin
            if (seq_idle && !fifo_out_valid)
            begin
              bus_reg <= BUS_MEMRD;
            end
          end
          else
          begin
            bus_reg <= BUS_ACK;
            case (req_addr_reg)
              OFS_CTRL[6:1]:     data_o <= ctrl_reg;
              OFS_PRESCALE[6:1]: data_o <= prescale_reg;
              OFS_INTERVAL[6:1]: data_o <= interval_reg;
              OFS_WPTR[6:1]:     data_o <= wptr_reg;
              OFS_VECTOR[6:1]:   data_o <= {8'h00, vector_reg};
              default:           data_o <= RESET_WORD;
            endcase
          end
        end
        BUS_MEMRD:
        begin
          data_o  <= mem_q_reg;
          bus_reg <= BUS_ACK;
        end
        BUS_ACK:
        begin
          ack_n_o   <= 1'b0;
          data_oe_o <= req_rd_reg || req_int_reg;
          bus_reg   <= BUS_HOLD;
        end
        BUS_HOLD:
        begin
          if (io_sel_n_i && int_sel_n_i)
          begin
            bus_reg <= BUS_IDLE;
          end
        end
        default:
        begin
          bus_reg <= BUS_IDLE;
        end
      endcase
    end
  end

  // Register writes, taken in the serve state.
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ctrl_reg     <= RESET_WORD;
      prescale_reg <= RESET_WORD;
      interval_reg <= RESET_WORD;
      wptr_reg     <= RESET_WORD;
      vector_reg   <= RESET_VECTOR;
      sw_start_reg <= 1'b0;
      for (int c = 0; c < NUM_CH; c++)
      begin
        dac_reg[c] <= RESET_WORD;
      end
    end
    else
    begin
      sw_start_reg <= 1'b0;
      if (bus_reg == BUS_SERVE && !req_rd_reg && !req_int_reg)
      begin
        case (req_addr_reg)
          OFS_CTRL[6:1]:     ctrl_reg     <= req_data_reg;
          OFS_PRESCALE[6:1]: prescale_reg <= req_data_reg;
          OFS_INTERVAL[6:1]: interval_reg <= req_data_reg;
          OFS_WPTR[6:1]:     wptr_reg     <= req_data_reg;
          OFS_START[6:1]:    sw_start_reg <= req_data_reg[START_BIT];
          OFS_VECTOR[6:1]:   vector_reg   <= req_data_reg[7:0];
          default:
          begin
            if (req_addr_reg[5:3] == OFS_DAC0[6:4])
            begin
              dac_reg[req_addr_reg[2:0]] <= req_data_reg;
            end
          end
        endcase
      end
      if (wdata_wr && ctrl_reg[CTL_AUTOINC_BIT])
      begin
        wptr_reg <= wptr_reg + 16'h0001;
      end
    end
  end

  // Checks.
  property p_ext_only_sw;
    @(posedge clock_i) disable iff (!rst_b_i)
    (ext_only && conv_go) |-> ext_fall;
  endproperty
  a_ext_only_sw: assert property (p_ext_only_sw) else $error("start without pin pulse");

  property p_load_all;
    @(posedge clock_i) disable iff (!rst_b_i)
    (seq_reg == SEQ_LOAD) |=> dac_load_o ##1 !dac_load_o;
  endproperty
  a_load_all: assert property (p_load_all) else $error("load pulse wrong");

  property p_no_drive;
    @(posedge clock_i) disable iff (!rst_b_i)
    ext_only [*2] |-> !outside_trigger_oe_o;
  endproperty
  a_no_drive: assert property (p_no_drive) else $error("pin driven in input mode");

  property p_master_pulse;
    @(posedge clock_i) disable iff (!rst_b_i)
    (dac_load_o && trig_mode == TRIG_DRIVE_OUT && outside_trigger_oe_o)
      |=> !outside_trigger_n_o;
  endproperty
  a_master_pulse: assert property (p_master_pulse) else $error("no master pulse");

  sequence s_reg_start;
    sw_start_reg && !ext_only && mode == MODE_SINGLE_REG && seq_idle;
  endsequence
  property p_reg_start;
    @(posedge clock_i) disable iff (!rst_b_i)
    s_reg_start |-> ##2 (dac_load_o && dac_code_o[15:0] == $past(dac_reg[0], 2));
  endproperty
  a_reg_start: assert property (p_reg_start) else $error("register start failed");

  property p_autoinc;
    @(posedge clock_i) disable iff (!rst_b_i)
    (wdata_wr && ctrl_reg[CTL_AUTOINC_BIT]) |=> wptr_reg == $past(wptr_reg) + 16'h0001;
  endproperty
  a_autoinc: assert property (p_autoinc) else $error("pointer did not advance");

  property p_once_stop;
    @(posedge clock_i) disable iff (!rst_b_i)
    ($fell(running_reg) && $past(cycle_mode)) |-> $past(conv_addr_reg) == LAST_ADDR;
  endproperty
  a_once_stop: assert property (p_once_stop) else $error("pass stopped early");

  property p_irq_end;
    @(posedge clock_i) disable iff (!rst_b_i)
    (seq_reg == SEQ_LOAD && running_reg && mode == MODE_ONCE_IRQ
     && conv_addr_reg == LAST_ADDR) |=> !irq_req_n_o;
  endproperty
  a_irq_end: assert property (p_irq_end) else $error("no request at pass end");

  sequence s_int_taken;
    bus_reg == BUS_SERVE && req_int_reg;
  endsequence
  property p_int_ack;
    @(posedge clock_i) disable iff (!rst_b_i)
    s_int_taken |=> irq_req_n_o ##1 (!ack_n_o && data_oe_o && data_o[7:0] == vector_reg);
  endproperty
  a_int_ack: assert property (p_int_ack) else $error("acknowledge cycle wrong");
endmodule // dwt_top
`default_nettype wire

// ---- sim/dwt_carrier.sv ----
`timescale 1ns/1ps
`default_nettype none
module dwt_carrier (
  // Clock
  input  wire logic        clock_i,
  // Module answers
  input  wire logic        ack_n_i,
  input  wire logic [15:0] data_i,
  // Bus requests
  output logic             io_sel_n_o,
  output logic             int_sel_n_o,
  output logic             rd_wr_n_o,
  output logic      [5:0]  addr_o,
  output logic      [15:0] data_o
);
  initial
  begin
    {io_sel_n_o, int_sel_n_o, rd_wr_n_o} = 3'h7;
    addr_o = 6'h00;
    data_o = 16'h0000;
  end
  // The request holds until the edge that samples acknowledge low.
  task automatic xfer(input logic iack, input logic rd, input logic [6:0] ofs,
                      input logic [15:0] wd, output logic [15:0] rdat);
    @(negedge clock_i);
    addr_o = iack ? 6'h00 : ofs[6:1];
    rd_wr_n_o = rd;
    data_o = wd;
    io_sel_n_o = iack;
    int_sel_n_o = !iack;
    // A module that never answers is caught by the bench's cycle ceiling.
    @(posedge clock_i);
    while (ack_n_i !== 1'b0)
    begin
      @(posedge clock_i);
    end
    rdat = data_i;
    @(negedge clock_i);
    {io_sel_n_o, int_sel_n_o} = 2'h3;
    // Released lines must not keep showing the last value.
    data_o = ~wd;
    addr_o = ~addr_o;
  endtask
endmodule // dwt_carrier
`default_nettype wire

// ---- sim/dac_waveform_trigger_control_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module dac_waveform_trigger_control_bench;
  import dwt_pkg::*;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic io_sel_n, int_sel_n, rd_wr_n, data_oe, ack_n, irq_n, trig_drv_n, trig_o, trig_oe, dac_load;
  logic [5:0] addr;
  logic [15:0] wdata, rdata, rd;
  logic [15:0] code_q [8];
  logic [127:0] dac_code;
  int err_total = 0, samples_checked = 0, cyc = 0, loads = 0, l0, c1;
  // The pin has a pull-up: idle high unless someone drives it.
  wire logic pin_n = trig_oe ? trig_o : trig_drv_n;
  always #25 clock_i = ~clock_i;
  dwt_top DUT (.clock_i(clock_i), .rst_b_i(rst_b_i), .io_sel_n_i(io_sel_n),
    .int_sel_n_i(int_sel_n), .rd_wr_n_i(rd_wr_n), .addr_i(addr), .data_i(wdata),
    .data_o(rdata), .data_oe_o(data_oe), .ack_n_o(ack_n), .irq_req_n_o(irq_n),
    .outside_trigger_n_i(pin_n), .outside_trigger_n_o(trig_o),
    .outside_trigger_oe_o(trig_oe), .dac_code_o(dac_code), .dac_load_o(dac_load));
  dwt_carrier car (.clock_i(clock_i), .ack_n_i(ack_n), .data_i(rdata),
    .io_sel_n_o(io_sel_n), .int_sel_n_o(int_sel_n), .rd_wr_n_o(rd_wr_n),
    .addr_o(addr), .data_o(wdata));
  task results();
    $display("checks=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clock_i)
  begin
    cyc++;
    if (dac_load === 1'b1)
      loads++;
    if (cyc == 80000)
    begin
      err_total++;
      results();
    end
  end
  task check(input logic [127:0] seen, input logic [127:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr(input logic [6:0] o, input logic [15:0] d);
    car.xfer(1'b0, 1'b0, o, d, rd);
  endtask
  task settle(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  task cnt(input int exp);
    check(128'(loads - l0), 128'(exp));
  endtask
  function automatic logic [127:0] pack();
    for (int c = 0; c < 8; c++)
      pack[16*c +: 16] = code_q[c];
  endfunction
  // Clock cycles between conversions for prescaler p and timer t.
  function automatic int gap(input int p, input int t);
    return p * t * CLK_MHZ / TICKS_PER_US;
  endfunction
  initial
  begin
    trig_drv_n = 1'b1;
    void'($urandom(4779));
    repeat (3) @(negedge clock_i);
    rst_b_i = 1'b1;
    check(128'(irq_n), 128'h1);
    wr(OFS_VECTOR, 16'h005A);
    car.xfer(1'b0, 1'b1, OFS_VECTOR, 16'h0000, rd);
    check(128'(rd), 128'h5A);
    wr(OFS_CTRL, 16'h0100);
    for (int c = 0; c < 8; c++)
    begin
      code_q[c] = (c == 0) ? 16'h7FFF : (c == 1) ? 16'h8000 : 16'($urandom);
      wr(OFS_DAC0 + 7'(2 * c), code_q[c]);
    end
    check(dac_code, 128'h0);
    l0 = loads;
    wr(OFS_START, 16'h0001);
    settle(20);
    cnt(1);
    check(dac_code, pack());
    wr(OFS_CTRL, 16'h0120);
    l0 = loads;
    wr(OFS_START, 16'h0001);
    settle(30);
    cnt(0);
    trig_drv_n = 1'b0;
    settle(4);
    trig_drv_n = 1'b1;
    settle(20);
    cnt(1);
    check(128'(trig_oe), 128'h0);
    wr(OFS_PRESCALE, 16'h0001);
    wr(OFS_INTERVAL, 16'h0008);
    wr(OFS_CTRL, 16'h0520);
    l0 = loads;
    trig_drv_n = 1'b0;
    settle(4);
    trig_drv_n = 1'b1;
    settle(200);
    cnt(1);
    wr(OFS_CTRL, 16'h0200);
    wr(OFS_WPTR, 16'h0000);
    wr(OFS_WDATA, 16'h8000);
    wr(OFS_CTRL, 16'h0201);
    wr(OFS_WDATA, 16'h0000);
    wr(OFS_START, 16'h0001);
    settle(30);
    check(128'(dac_code[31:0]), 128'h8000);
    wr(OFS_CTRL, 16'h0317);
    wr(OFS_WPTR, 16'h0000);
    wr(OFS_WDATA, 16'h8000);
    wr(OFS_WDATA, 16'h0000);
    car.xfer(1'b0, 1'b1, OFS_WPTR, 16'h0000, rd);
    check(128'(rd), 128'h2);
    wr(OFS_WPTR, 16'h0000);
    car.xfer(1'b0, 1'b1, OFS_WDATA, 16'h0000, rd);
    check(128'(rd), 128'h8000);
    wr(OFS_CTRL, 16'h0400);
    l0 = loads;
    wr(OFS_START, 16'h0001);
    while (loads < l0 + 2) @(negedge clock_i);
    c1 = cyc;
    while (loads < l0 + 3) @(negedge clock_i);
    check(128'(cyc - c1), 128'(gap(1, 8)));
    while (irq_n !== 1'b0) @(negedge clock_i);
    settle(1);
    cnt(2048);
    settle(100);
    cnt(2048);
    check(128'(irq_n), 128'h0);
    car.xfer(1'b1, 1'b1, 7'h00, 16'h0000, rd);
    check(128'(rd[7:0]), 128'h5A);
    settle(2);
    check(128'(irq_n), 128'h1);
    wr(OFS_CTRL, 16'h0540);
    l0 = loads;
    wr(OFS_START, 16'h0001);
    while (loads < l0 + 1) @(negedge clock_i);
    settle(1);
    check(128'({trig_oe, pin_n}), 128'h2);
    results();
  end
endmodule // dac_waveform_trigger_control_bench
`default_nettype wire
